/* File: hw/dsb_bank_mem.sv */
// Purpose : One storage array with per-lane write enables
// Assumes : One write and one read port on the same clock
// Notes   : Read data come out of a register one cycle after the request
`timescale 1ns/10ps
module dsb_bank_mem #(
  parameter int DATA_W = dsb_pkg::DATA_W_WIDE,
  parameter int ROW_W  = dsb_pkg::ADDR_W_WIDE - 1,
  parameter int LANES  = dsb_pkg::DATA_W_WIDE / dsb_pkg::LANE_W
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              wr_en,
  input  wire logic [ROW_W-1:0]  wr_row,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [LANES-1:0]  wr_lane_en,
  input  wire logic              rd_en,
  input  wire logic [ROW_W-1:0]  rd_row,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] cells [2**ROW_W];
  logic [DATA_W-1:0] rd_data_q;

  // ----------------------------------------------------------------
  // Array write; lanes left disabled keep their old contents
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      for (int l = 0; l < LANES; l++) begin
        if (wr_lane_en[l]) begin
          cells[wr_row][l*dsb_pkg::LANE_W +: dsb_pkg::LANE_W] <=
            wr_data[l*dsb_pkg::LANE_W +: dsb_pkg::LANE_W];
        end
      end
    end
  end

  // Registered read; a same-cycle write to the row returns old data
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= cells[rd_row];
    end
  end

  assign rd_data = rd_data_q;

endmodule : dsb_bank_mem

/* File: hw/dsb_fifo.sv */
// Purpose : Small word FIFO with valid and ready on both sides
// Assumes : Push and pop on the same clock
// Notes   : Output word is shown combinationally from the head slot
`timescale 1ns/10ps
module dsb_fifo #(
  parameter int W     = dsb_pkg::DATA_W_WIDE,
  parameter int DEPTH = dsb_pkg::FIFO_DEPTH
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [PW:0]             wr_ptr;
    logic [PW:0]             rd_ptr;
  } dsb_fifo_s;

  dsb_fifo_s q;
  dsb_fifo_s d;
  logic      full;
  logic      empty;

  // ----------------------------------------------------------------
  // Pointer compare: extra bit tells full from empty
  // ----------------------------------------------------------------
  assign empty     = (q.wr_ptr == q.rd_ptr);
  assign full      = (q.wr_ptr[PW] != q.rd_ptr[PW]) &&
                     (q.wr_ptr[PW-1:0] == q.rd_ptr[PW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = q.slot[q.rd_ptr[PW-1:0]];

  // Next state of pointers and storage
  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.slot[q.wr_ptr[PW-1:0]] = in_data;
      d.wr_ptr                 = q.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : dsb_fifo

/* File: hw/dsb_pkg.sv */
// Purpose : Shared constants and types of the two-word burst SRAM pin interface
// Assumes : Wide configuration is the default; narrow one changes widths only
// Notes   : Widths here are defaults for the top-level parameters
package dsb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int LANE_W       = 9;   // One byte-write select gates nine bits
  localparam int DATA_W_WIDE  = 36;  // Wide data bus
  localparam int DATA_W_NARR  = 18;  // Narrow data bus
  localparam int ADDR_W_WIDE  = 19;  // Address bits of the wide configuration
  localparam int ADDR_W_NARR  = 20;  // Address bits of the narrow configuration
  localparam int NUM_BANKS    = 2;   // Two equal arrays of half depth
  localparam int BURST_WORDS  = 2;   // Every transaction moves two words
  localparam int FIFO_DEPTH   = 8;   // Read data buffer depth

  // ----------------------------------------------------------------
  // Synchroniser layout and reset values
  // ----------------------------------------------------------------
  localparam int SYNC_FIRST   = 0;   // Stage that meets the pin
  localparam int SYNC_LAST    = 1;   // Stage the logic reads
  localparam int EDGE_PREV    = 2;   // Delayed copy for edge detection
  localparam logic OE_RELEASED = 1'h1;  // Output enable low means driving
  localparam logic OE_DRIVING  = 1'h0;

  // ----------------------------------------------------------------
  // Transaction sequencer states, Gray on the steps out of ST_IDLE and on to the second state of each path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_WR_W0   = 3'h1,
    ST_WR_W1   = 3'h3,
    ST_RD_LAT  = 3'h4,
    ST_RD_PUSH = 3'h5
  } dsb_state_e;

endpackage : dsb_pkg

/* File: hw/dsb_sram_port.sv */
// Purpose : Device side of a double-data-rate SRAM port with two-word bursts
// Assumes : Link clocks are slow against core_clk and sampled as plain inputs
// Notes   : Storage, read buffer and pin sequencing of one port
//
// Function
// - Write data captured on rising edges of both input clocks
// - Read data launched on output clock edges, or input clocks in single mode
// - Data outputs released to high impedance whenever no read is driven
// - Low load strobe starts a cycle, taking address and direction
// - Each transaction moves exactly two words
// - Active-low byte selects sampled on the same edge as their data
// - Deselected byte lanes are discarded and storage keeps old bytes
// - Each byte select gates one nine-bit lane, lowest lane first
// - Lowest address bit seeds a linear burst counter for word two
// - Twenty address bits narrow, nineteen address bits wide
// - Read and write share one set of address inputs
// - Address inputs ignored in cycles without a load
// - Storage is two equal arrays of half the depth each
// - Data bus is 18 or 36 bits, shared by input and output
// - With load low, high select means read, low means write
// - Accesses start only on a rising edge of the positive input clock
`timescale 1ns/10ps
module dsb_sram_port #(
  parameter int DATA_W = dsb_pkg::DATA_W_WIDE,
  parameter int ADDR_W = dsb_pkg::ADDR_W_WIDE
) (
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  input  wire logic                            k_clk,
  input  wire logic                            k_clk_n,
  input  wire logic                            c_clk,
  input  wire logic                            c_clk_n,
  input  wire logic                            single_clk_mode,
  input  wire logic                            load_strobe_n,
  input  wire logic                            read_sel,
  input  wire logic [ADDR_W-2:0]               addr,
  input  wire logic                            burst_start_lsb,
  input  wire logic [DATA_W/dsb_pkg::LANE_W-1:0] byte_write_sel_n,
  input  wire logic [DATA_W-1:0]               dq_in,
  output logic      [DATA_W-1:0]               dq_out,
  output logic                                 dq_oe_n
);

  localparam int LANES = DATA_W / dsb_pkg::LANE_W;
  localparam int ROW_W = ADDR_W - 1;
  localparam int FL    = dsb_pkg::SYNC_LAST;
  localparam int EP    = dsb_pkg::EDGE_PREV;

  // ----------------------------------------------------------------
  // State of the port
  // ----------------------------------------------------------------
  typedef struct packed {
    dsb_pkg::dsb_state_e    st;
    logic [2:0]             k_s;
    logic [2:0]             kn_s;
    logic [2:0]             c_s;
    logic [2:0]             cn_s;
    logic [1:0]             mode_s;
    logic [1:0]             load_s;
    logic [1:0]             rd_s;
    logic [1:0][ROW_W-1:0]  addr_s;
    logic [1:0]             lsb_s;
    logic [1:0][LANES-1:0]  lane_s;
    logic [1:0][DATA_W-1:0] dq_s;
    logic [ROW_W-1:0]       row_q;
    logic                   lsb_q;
    logic [1:0][DATA_W-1:0] hold;
    logic                   push_idx;
    logic [DATA_W-1:0]      dq_out;
    logic                   dq_oe_n;
  } dsb_port_s;

  dsb_port_s                          q;
  dsb_port_s                          d;
  logic                               k_rise;
  logic                               kn_rise;
  logic                               out_edge;
  logic                               start;
  logic [dsb_pkg::NUM_BANKS-1:0]      m_we;
  logic                               m_re;
  logic [LANES-1:0]                   m_lane;
  logic [dsb_pkg::NUM_BANKS-1:0][DATA_W-1:0] m_rdata;
  logic                               f_in_valid;
  logic                               f_in_ready;
  logic [DATA_W-1:0]                  f_in_data;
  logic                               f_out_valid;
  logic [DATA_W-1:0]                  f_out_data;

  // ----------------------------------------------------------------
  // Edge detection on the synchronised link clocks
  // ----------------------------------------------------------------
  // Only the second stage and its delayed copy are looked at
  assign k_rise   = q.k_s[FL] & ~q.k_s[EP];
  assign kn_rise  = q.kn_s[FL] & ~q.kn_s[EP];
  assign out_edge = q.mode_s[FL] ? (k_rise | kn_rise)
                                 : ((q.c_s[FL] & ~q.c_s[EP]) | (q.cn_s[FL] & ~q.cn_s[EP]));
  // New transaction only on a K rise with load low; idle or last write edge
  assign start    = k_rise && !q.load_s[FL] &&
                    (q.st == dsb_pkg::ST_IDLE || q.st == dsb_pkg::ST_WR_W1);
  // Lane enables straight from the inverted, same-edge byte selects
  assign m_lane   = ~q.lane_s[FL];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Pins pass two flops each; data and selects share the clocks' delay
  always_comb begin
    d            = q;
    m_we         = '0;
    m_re         = 1'b0;
    f_in_valid   = 1'b0;
    f_in_data    = q.hold[q.push_idx];
    d.k_s        = {q.k_s[1:0], k_clk};
    d.kn_s       = {q.kn_s[1:0], k_clk_n};
    d.c_s        = {q.c_s[1:0], c_clk};
    d.cn_s       = {q.cn_s[1:0], c_clk_n};
    d.mode_s     = {q.mode_s[0], single_clk_mode};
    d.load_s     = {q.load_s[0], load_strobe_n};
    d.rd_s       = {q.rd_s[0], read_sel};
    d.lsb_s      = {q.lsb_s[0], burst_start_lsb};
    d.addr_s[1]  = q.addr_s[0];
    d.addr_s[0]  = addr;
    d.lane_s[1]  = q.lane_s[0];
    d.lane_s[0]  = byte_write_sel_n;
    d.dq_s[1]    = q.dq_s[0];
    d.dq_s[0]    = dq_in;

    unique case (q.st)
      dsb_pkg::ST_IDLE: begin
      end
      // First word on the K# rise that follows the load
      dsb_pkg::ST_WR_W0: begin
        if (kn_rise) begin
          m_we[q.lsb_q] = 1'b1;
          d.st          = dsb_pkg::ST_WR_W1;
        end
      end
      // Second word on the next K rise, bank picked by the burst counter
      dsb_pkg::ST_WR_W1: begin
        if (k_rise) begin
          m_we[~q.lsb_q] = 1'b1;
          d.st           = dsb_pkg::ST_IDLE;
        end
      end
      // Both arrays read together; order words by the seed bit
      dsb_pkg::ST_RD_LAT: begin
        d.hold[0]  = m_rdata[q.lsb_q];
        d.hold[1]  = m_rdata[~q.lsb_q];
        d.push_idx = 1'b0;
        d.st       = dsb_pkg::ST_RD_PUSH;
      end
      // Stalls while the buffer is full; loads are not seen meanwhile
      dsb_pkg::ST_RD_PUSH: begin
        f_in_valid = 1'b1;
        if (f_in_ready) begin
          if (q.push_idx) begin
            d.st = dsb_pkg::ST_IDLE;
          end else begin
            d.push_idx = 1'b1;
          end
        end
      end
      default: begin
        d.st = dsb_pkg::ST_IDLE;
      end
    endcase

    // Load cycle defines the whole transaction
    if (start) begin
      d.row_q = q.addr_s[FL];
      d.lsb_q = q.lsb_s[FL];
      if (q.rd_s[FL]) begin
        m_re = 1'b1;
        d.st = dsb_pkg::ST_RD_LAT;
      end else begin
        d.st = dsb_pkg::ST_WR_W0;
      end
    end

    // Each output clock edge shows one word or releases the pins
    if (out_edge) begin
      if (f_out_valid) begin
        d.dq_out  = f_out_data;
        d.dq_oe_n = dsb_pkg::OE_DRIVING;
      end else begin
        d.dq_oe_n = dsb_pkg::OE_RELEASED;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q         <= '0;
      q.dq_oe_n <= dsb_pkg::OE_RELEASED;
      // Complement clocks idle high while K and C sit low; avoids a false rise after reset
      q.kn_s    <= '1;
      q.cn_s    <= '1;
    end else begin
      q <= d;
    end
  end

  assign dq_out  = q.dq_out;
  assign dq_oe_n = q.dq_oe_n;

  // ----------------------------------------------------------------
  // Two half-depth arrays
  // ----------------------------------------------------------------
  for (genvar b = 0; b < dsb_pkg::NUM_BANKS; b++) begin : g_bank
    dsb_bank_mem #(
      .DATA_W (DATA_W),
      .ROW_W  (ROW_W),
      .LANES  (LANES)
    ) u_mem (
      .core_clk   (core_clk),
      .reset      (reset),
      .wr_en      (m_we[b]),
      .wr_row     (q.row_q),
      .wr_data    (q.dq_s[FL]),
      .wr_lane_en (m_lane),
      .rd_en      (m_re),
      .rd_row     (q.addr_s[FL]),
      .rd_data    (m_rdata[b])
    );
  end

  // ----------------------------------------------------------------
  // Read data buffer between array and output clocks
  // ----------------------------------------------------------------
  dsb_fifo #(
    .W     (DATA_W),
    .DEPTH (dsb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (out_edge),
    .out_data  (f_out_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Released after an output edge with nothing to send
  a_oe_release_idle: assert property (
    (out_edge && !f_out_valid) |=> dq_oe_n
  ) else $error("data pins not released without read data");

  // Output word changes only right after an output edge
  a_launch_on_edge: assert property (
    ($changed(dq_out) || $fell(dq_oe_n)) |-> $past(out_edge)
  ) else $error("read data launched off an output clock edge");

  // No load, no change to the captured address
  a_addr_ignored: assert property (
    (k_rise && q.load_s[FL] && q.st == dsb_pkg::ST_IDLE)
      |=> (q.st == dsb_pkg::ST_IDLE) && $stable(q.row_q) && $stable(q.lsb_q)
  ) else $error("address taken without load strobe");

  // A write load enters the word-one state with no write in that cycle
  a_write_sequence: assert property (
    (start && !q.rd_s[FL]) |=> (q.st == dsb_pkg::ST_WR_W0) && (m_we == '0)
  ) else $error("write load did not enter first word state");

  // Direction follows the select at the load edge
  a_dir_decode: assert property (
    start |=> (q.st == (($past(q.rd_s[FL])) ? dsb_pkg::ST_RD_LAT : dsb_pkg::ST_WR_W0))
  ) else $error("direction decoded wrongly");

  // Second write word goes to the other bank
  a_burst_second: assert property (
    (q.st == dsb_pkg::ST_WR_W1 && k_rise) |-> (m_we[~q.lsb_q] && !m_we[q.lsb_q])
  ) else $error("second word written to wrong bank");

  // Lane enables equal the inverted pin selects seen at the same capture edge
  a_lane_gate: assert property (
    (|m_we) |-> (m_lane == ~$past(byte_write_sel_n, 2)) && ($countones(m_we) == 1)
  ) else $error("byte lanes not gated by selects");

  // Transactions begin only at a K rise
  a_start_on_k: assert property (
    ($past(q.st) == dsb_pkg::ST_IDLE && q.st != dsb_pkg::ST_IDLE) |-> $past(k_rise)
  ) else $error("access started off a K rise");

  // A read with room pushes its two words within three cycles
  a_read_two_words: assert property (
    (q.st == dsb_pkg::ST_RD_LAT) ##1 (f_in_valid && f_in_ready) [*2]
      |=> (q.st != dsb_pkg::ST_RD_PUSH)
  ) else $error("read pushed other than two words");

  c_write_burst: cover property (
    (q.st == dsb_pkg::ST_WR_W0) ##[1:80] (q.st == dsb_pkg::ST_WR_W1 && k_rise)
  );
  c_read_driven: cover property (
    $fell(dq_oe_n) ##[1:80] $rose(dq_oe_n)
  );
  c_single_mode: cover property (
    q.mode_s[FL] && out_edge && f_out_valid
  );
  c_back_to_back: cover property (
    start && q.st == dsb_pkg::ST_WR_W1
  );

endmodule : dsb_sram_port

/* File: sim/dsb_ctrl_model.sv */
// Purpose : Memory controller model driving link clocks, commands and write data
// Assumes : Link clocks stand still between frames; half period is 20 core cycles
// Notes   : Released lines show the inverse of their last value
`timescale 1ns/10ps
module dsb_ctrl_model #(
  parameter int DATA_W = dsb_pkg::DATA_W_WIDE,
  parameter int ADDR_W = dsb_pkg::ADDR_W_WIDE,
  parameter int LANES  = DATA_W / dsb_pkg::LANE_W
) (
  input  wire logic              core_clk,
  output logic                   k_clk,
  output logic                   k_clk_n,
  output logic                   c_clk,
  output logic                   c_clk_n,
  output logic                   load_strobe_n,
  output logic                   read_sel,
  output logic [ADDR_W-2:0]      addr,
  output logic                   burst_start_lsb,
  output logic [LANES-1:0]       byte_write_sel_n,
  output logic [DATA_W-1:0]      dq_in,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              dq_oe_n
);
  logic [DATA_W-1:0] ctl_dq;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Shared data wire: device wins while it drives, else the controller
  assign dq_in   = (dq_oe_n == 1'b0) ? dq_out : ctl_dq;
  assign k_clk_n = ~k_clk;
  assign c_clk_n = ~c_clk;

  // Idle levels at time zero, clocks low so no edge is seen at release
  initial begin
    k_clk            = 1'b0;
    c_clk            = 1'b0;
    load_strobe_n    = 1'b1;
    read_sel         = 1'b0;
    addr             = '0;
    burst_start_lsb  = 1'b0;
    byte_write_sel_n = '1;
    ctl_dq           = '0;
  end

  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  task automatic gap(input int n);
    repeat (n) @(posedge core_clk);
  endtask : gap

  // Load cycle plus first data word; changes stay 10 cycles off every edge
  task automatic frame(input logic rd, input logic [ADDR_W-2:0] row, input logic lsb,
                       input logic [DATA_W-1:0] w0, input logic [LANES-1:0] b0);
    @(posedge core_clk);
    load_strobe_n   <= 1'b0;
    read_sel        <= rd;
    addr            <= row;
    burst_start_lsb <= lsb;
    gap(10);
    k_clk <= 1'b1;
    gap(10);
    load_strobe_n   <= 1'b1;
    addr            <= ~row;
    burst_start_lsb <= ~lsb;
    ctl_dq           <= rd ? ~ctl_dq : w0;
    byte_write_sel_n <= rd ? ~byte_write_sel_n : b0;
    gap(10);
    k_clk <= 1'b0;
    gap(10);
  endtask : frame

  // Whole write burst: exactly two words on consecutive clock edges
  task automatic write(input logic [ADDR_W-2:0] row, input logic lsb,
                       input logic [DATA_W-1:0] w0, input logic [LANES-1:0] b0,
                       input logic [DATA_W-1:0] w1, input logic [LANES-1:0] b1);
    frame(1'b0, row, lsb, w0, b0);
    ctl_dq           <= w1;
    byte_write_sel_n <= b1;
    gap(10);
    k_clk <= 1'b1;
    gap(10);
    ctl_dq           <= ~w1;
    byte_write_sel_n <= ~b1;
    gap(10);
    k_clk <= 1'b0;
    gap(10);
  endtask : write

  // Second write word on the clock rise that also loads the next transaction
  task automatic chain(input logic [DATA_W-1:0] w1, input logic [LANES-1:0] b1);
    ctl_dq           <= w1;
    byte_write_sel_n <= b1;
  endtask : chain

  // Address moves under a clock rise without load, load low only at the negative rise
  task automatic stray(input logic [ADDR_W-2:0] row);
    @(posedge core_clk);
    addr <= row;
    gap(10);
    k_clk <= 1'b1;
    gap(10);
    load_strobe_n <= 1'b0;
    read_sel      <= 1'b0;
    gap(10);
    k_clk <= 1'b0;
    gap(10);
    load_strobe_n <= 1'b1;
    gap(10);
  endtask : stray

  // One output clock edge (input pair in single mode), then sample the bus
  task automatic out_edge(input logic single, input logic move, output logic oe_n,
                          output logic [DATA_W-1:0] q);
    @(posedge core_clk);
    if (move && single) begin
      k_clk <= ~k_clk;
    end else if (move) begin
      c_clk <= ~c_clk;
    end
    gap(19);
    oe_n = dq_oe_n;
    q    = dq_out;
  endtask : out_edge
endmodule : dsb_ctrl_model

/* File: sim/test_ddr_sram_burst2_pin_interface.sv */
// Purpose : Self-checking bench of the two-word burst SRAM pin interface
// Assumes : Wide configuration; controller model drives all link pins
// Notes   : Expected memory kept in the bench, merged per byte lane
`timescale 1ns/10ps
module test_ddr_sram_burst2_pin_interface;
  localparam int   LIMIT = 20000;
  localparam logic [17:0] ROW_A = 18'h00a5c;
  localparam logic [17:0] ROW_B = 18'h3ffff;

  logic core_clk, reset, single_mode;
  logic k_clk, k_clk_n, c_clk, c_clk_n, load_strobe_n, read_sel, burst_start_lsb;
  logic [17:0] addr;
  logic [3:0]  byte_write_sel_n;
  logic [35:0] dq_in, dq_out;
  logic        dq_oe_n;
  logic [35:0] exp_mem [logic [18:0]];
  int          err_total, n_compared, cyc;

  dsb_sram_port DUT (.core_clk(core_clk), .reset(reset), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .c_clk(c_clk), .c_clk_n(c_clk_n), .single_clk_mode(single_mode),
    .load_strobe_n(load_strobe_n), .read_sel(read_sel), .addr(addr),
    .burst_start_lsb(burst_start_lsb), .byte_write_sel_n(byte_write_sel_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  dsb_ctrl_model model (.core_clk(core_clk), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .c_clk(c_clk), .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n), .read_sel(read_sel),
    .addr(addr), .burst_start_lsb(burst_start_lsb), .byte_write_sel_n(byte_write_sel_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // A stuck sequence ends the run here instead of spinning forever
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // Lanes with a low select take the new byte, the rest keep the old one
  function automatic logic [35:0] merge(input logic [18:0] k, input logic [35:0] w,
                                        input logic [3:0] b);
    logic [35:0] v;
    v = exp_mem.exists(k) ? exp_mem[k] : 'x;
    for (int l = 0; l < 4; l++) begin
      if (!b[l]) v[9*l+:9] = w[9*l+:9];
    end
    return v;
  endfunction : merge

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Write burst: word one to the seeded bank, word two to the other one
  task automatic wr(input logic [17:0] row, input logic lsb, input logic [35:0] w0,
                    input logic [3:0] b0, input logic [35:0] w1, input logic [3:0] b1);
    model.write(row, lsb, w0, b0, w1, b1);
    exp_mem[{row, lsb}]  = merge({row, lsb}, w0, b0);
    exp_mem[{row, ~lsb}] = merge({row, ~lsb}, w1, b1);
    chk_flag(dq_oe_n, 1'b1);
  endtask : wr

  // Read burst, then edges until the bus is released again
  task automatic rd_chk(input logic single, input logic [17:0] row, input logic lsb);
    logic        oe_n;
    logic [35:0] q;
    model.frame(1'b1, row, lsb, '0, '1);
    for (int i = 0; i < 4; i++) begin
      if (single && i == 3) break;
      model.out_edge(single, !(single && i == 0), oe_n, q);
      chk_flag(oe_n, (i < 2) ? 1'b0 : 1'b1);
      if (i < 2) chk_word(q, exp_mem[{row, lsb ^ i[0]}]);
    end
  endtask : rd_chk

  // Back-to-back: the rise taking write word two also loads a read of another row
  task automatic wr_rd(input logic [35:0] w0, input logic [35:0] w1);
    model.frame(1'b0, ROW_A, 1'b0, w0, 4'h0);
    model.chain(w1, 4'h0);
    exp_mem[{ROW_A, 1'b0}] = w0;
    exp_mem[{ROW_A, 1'b1}] = w1;
    rd_chk(1'b0, ROW_B, 1'b0);
    rd_chk(1'b0, ROW_A, 1'b0);
  endtask : wr_rd

  // Five reads with output clocks stopped overfill the buffer, then drain
  task automatic fifo_fill();
    logic        oe_n;
    logic [35:0] q;
    logic [18:0] keys[$];
    for (int r = 0; r < 5; r++) begin
      model.frame(1'b1, r[0] ? ROW_B : ROW_A, r[1], '0, '1);
      keys.push_back({r[0] ? ROW_B : ROW_A, r[1]});
      keys.push_back({r[0] ? ROW_B : ROW_A, ~r[1]});
    end
    for (int i = 0; i < 12; i++) begin
      model.out_edge(1'b0, 1'b1, oe_n, q);
      chk_flag(oe_n, (i < 10) ? 1'b0 : 1'b1);
      if (i < 10) chk_word(q, exp_mem[keys[i]]);
    end
  endtask : fifo_fill

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset       = 1'b1;
    single_mode = 1'b0;
    err_total   = 0;
    n_compared  = 0;
    cyc         = 0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_word(36'($bits(DUT.addr) + 1), 36'h13);
    chk_word(36'($bits(DUT.dq_out)), 36'h24);
    wr(ROW_A, 1'b0, 36'h123456789, 4'h0, 36'hfedcba987, 4'h0);
    rd_chk(1'b0, ROW_A, 1'b0);
    wr(ROW_B, 1'b1, 36'h0aaaa5555, 4'h0, 36'h955553333, 4'h0);
    rd_chk(1'b0, ROW_B, 1'b0);
    wr(ROW_A, 1'b1, 36'hfffffffff, 4'ha, 36'h000000000, 4'h5);
    rd_chk(1'b0, ROW_A, 1'b1);
    wr(ROW_A, 1'b0, 36'h5a5a5a5a5, 4'hf, 36'ha5a5a5a5a, 4'hf);
    rd_chk(1'b0, ROW_A, 1'b0);
    model.stray(ROW_B ^ 18'h00001);
    rd_chk(1'b0, ROW_B, 1'b1);
    single_mode <= 1'b1;
    rd_chk(1'b1, ROW_A, 1'b1);
    single_mode <= 1'b0;
    wr_rd(36'h13579bdf0, 36'h2468ace01);
    fifo_fill();
    summarize();
  end
endmodule : test_ddr_sram_burst2_pin_interface
